// ### rtl/rcm_pkg.sv
// Package: constants, mode codes and timing figures for the retrograde manager
package rcm_pkg;
   // Mode codes on the mode input
   typedef enum logic [1:0] {
      RCM_MODE_DUAL_TRACK    = 2'h0,
      RCM_MODE_DUAL_NONTRACK = 2'h1,
      RCM_MODE_ATRIAL_SENSE  = 2'h2,
      RCM_MODE_OTHER         = 2'h3
   } rcm_mode_t;
   // Clock rate and millisecond tick
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned TICK_MS         = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W          = 16;
   // Interval figures in ms
   localparam logic [11:0] VA_RETRO_MAX_MS = 12'h1c2;  // 450 ms
   localparam logic [11:0] VA_FARFIELD_MS  = 12'h096;  // 150 ms
   localparam logic [11:0] VA_TOL_MS       = 12'h00a;  // Change tolerance
   localparam logic [11:0] AV_TEST_EXT_MS  = 12'h032;  // Test AV lengthening
   localparam logic [11:0] SYNC_MIN_MS     = 12'h0fa;  // 250 ms
   localparam logic [11:0] SYNC_MAX_MS     = 12'h190;  // 400 ms
   // Counts
   localparam logic [1:0]  TEST_REPEATS    = 2'h3;
   localparam logic [1:0]  VS_END_COUNT    = 2'h3;
   localparam logic [1:0]  NO_AS_END_COUNT = 2'h3;
   localparam logic [5:0]  TEST_PERIOD_CYC = 6'h20;    // Cycles between tests
   localparam logic [11:0] MS_RESET        = 12'h000;
endpackage

// ### rtl/rcm_core.sv
// Retrograde conduction and premature ventricular event manager
module rcm_core (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        a_sense_pin,
   input  wire logic        v_sense_pin,
   input  wire logic [1:0]  mode,
   input  wire logic        post_ext_en,
   input  wire logic        sync_stim_en,
   input  wire logic        auto_switch_en,
   input  wire logic [11:0] escape_ms,
   input  wire logic [11:0] paced_av_ms,
   input  wire logic [11:0] sensed_av_ms,
   input  wire logic [11:0] av_offset_ms,
   input  wire logic [11:0] tracking_win_ms,
   input  wire logic [11:0] sync_interval_ms,
   output logic             a_stim,
   output logic             v_stim,
   output logic             a_sync_pace,
   output logic             premature_ventricular_event,
   output logic             ext_active,
   output logic             retro_test_active,
   output logic             retro_confirmed,
   output logic             nontracking
);
   // Pin synchronisers: first stage read only by second
   logic [1:0] a_sync_reg;
   logic [1:0] v_sync_reg;
   logic       a_prev_reg;
   logic       v_prev_reg;
   logic       a_ev;
   logic       v_ev;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         a_sync_reg <= 2'h0;
         v_sync_reg <= 2'h0;
         a_prev_reg <= 1'b0;
         v_prev_reg <= 1'b0;
      end else begin
         a_sync_reg <= {a_sync_reg[0], a_sense_pin};
         v_sync_reg <= {v_sync_reg[0], v_sense_pin};
         a_prev_reg <= a_sync_reg[1];
         v_prev_reg <= v_sync_reg[1];
      end
   end
   assign a_ev = a_sync_reg[1] & ~a_prev_reg;
   assign v_ev = v_sync_reg[1] & ~v_prev_reg;

   // Mode decode helpers
   function automatic logic is_dual(input logic [1:0] m);
      is_dual = (m == rcm_pkg::RCM_MODE_DUAL_TRACK) || (m == rcm_pkg::RCM_MODE_DUAL_NONTRACK);
   endfunction
   logic dual_m;
   logic vdd_m;
   logic track_m;
   assign dual_m  = is_dual(mode);
   assign vdd_m   = (mode == rcm_pkg::RCM_MODE_ATRIAL_SENSE);
   assign track_m = dual_m | vdd_m;

   // Millisecond tick prescaler, shared by every interval counter
   logic [rcm_pkg::TICK_W-1:0] pre_reg;
   logic                       tick_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pre_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (pre_reg == rcm_pkg::TICK_W'(rcm_pkg::TICK_CYCLES - 1)) begin
         pre_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         pre_reg  <= pre_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // Effective AV delay: sensed derived from paced in dual tracking
   logic [11:0] sav_eff;
   logic [11:0] av_eff;
   assign sav_eff = (mode == rcm_pkg::RCM_MODE_DUAL_TRACK) ?
                    (paced_av_ms - av_offset_ms) : sensed_av_ms;
   assign av_eff  = retro_test_active ? (sav_eff + rcm_pkg::AV_TEST_EXT_MS) : sav_eff;

   // Cycle timing state
   logic [11:0] vv_reg;        // Time since last V event
   logic [11:0] aa_reg;        // Time since last A event
   logic [11:0] av_reg;        // Time since tracked A sense
   logic [11:0] esc_lim_reg;   // Current escape limit
   logic        a_seen_reg;    // A event in this cycle
   logic        av_run_reg;    // AV delay running
   logic        pve_series_reg;
   logic [1:0]  a_cnt_reg;     // Non-far-field A senses per cycle
   logic        sync_due_reg;  // Sync pace wanted before V pace
   logic        v_exp;
   logic        a_early;
   logic        pve_now;
   assign pve_now = v_ev & ~a_seen_reg;
   assign a_early = a_ev & (vv_reg < tracking_win_ms);
   assign v_exp   = (vv_reg >= esc_lim_reg) & tick_reg;

   // Interval counters and escape scheduling
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vv_reg      <= rcm_pkg::MS_RESET;
         aa_reg      <= rcm_pkg::MS_RESET;
         av_reg      <= rcm_pkg::MS_RESET;
         esc_lim_reg <= rcm_pkg::MS_RESET;
         av_run_reg  <= 1'b0;
         ext_active  <= 1'b0;
      end else begin
         if (v_ev || v_stim) begin
            vv_reg     <= rcm_pkg::MS_RESET;
            av_run_reg <= 1'b0;
            if (pve_now && post_ext_en && track_m && !pve_series_reg) begin
               // Extension by paced or sensed AV delay
               esc_lim_reg <= escape_ms + (dual_m ? paced_av_ms : sensed_av_ms);
               ext_active  <= 1'b1;
            end else begin
               esc_lim_reg <= escape_ms;
               ext_active  <= 1'b0;
            end
         end else if (tick_reg && vv_reg != 12'hfff) begin
            vv_reg <= vv_reg + 12'h001;
         end
         if (a_ev || a_stim) begin
            aa_reg <= rcm_pkg::MS_RESET;
         end else if (tick_reg && aa_reg != 12'hfff) begin
            aa_reg <= aa_reg + 12'h001;
         end
         // Tracking: not in non-tracking or dual non-tracking
         if (a_ev && !nontracking && !a_early && mode != rcm_pkg::RCM_MODE_DUAL_NONTRACK
             && track_m && !av_run_reg) begin
            av_run_reg <= 1'b1;
            av_reg     <= rcm_pkg::MS_RESET;
         end else if (av_run_reg && tick_reg) begin
            av_reg <= av_reg + 12'h001;
         end
      end
   end

   // Cycle bookkeeping: A seen, series, A count
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         a_seen_reg     <= 1'b0;
         pve_series_reg <= 1'b0;
         a_cnt_reg      <= 2'h0;
      end else begin
         if (v_ev || v_stim) begin
            a_seen_reg <= 1'b0;
            a_cnt_reg  <= 2'h0;
            if (v_ev) begin
               pve_series_reg <= pve_now;
            end else begin
               pve_series_reg <= 1'b0;
            end
         end else begin
            if (a_ev || a_stim) begin
               a_seen_reg <= 1'b1;
            end
            // Far-field senses excluded from count
            if (a_ev && vv_reg >= rcm_pkg::VA_FARFIELD_MS && a_cnt_reg != 2'h3) begin
               a_cnt_reg <= a_cnt_reg + 2'h1;
            end
         end
      end
   end

   // Stimulus outputs, one-cycle pulses
   logic av_done;
   logic sync_time;
   assign av_done   = av_run_reg && tick_reg && (av_reg >= av_eff);
   assign sync_time = sync_due_reg && tick_reg && dual_m
                      && ((vv_reg + paced_av_ms) >= esc_lim_reg)
                      && (aa_reg >= sync_interval_ms);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         a_stim                      <= 1'b0;
         v_stim                      <= 1'b0;
         a_sync_pace                 <= 1'b0;
         premature_ventricular_event <= 1'b0;
         sync_due_reg                <= 1'b0;
      end else begin
         premature_ventricular_event <= pve_now;
         v_stim <= !v_stim && (v_exp || av_done);
         a_sync_pace <= 1'b0;
         a_stim      <= 1'b0;
         if (pve_now && sync_stim_en && dual_m && !pve_series_reg
             && aa_reg > sync_interval_ms) begin
            a_stim <= 1'b1;
         end else if (sync_time) begin
            a_stim       <= 1'b1;
            a_sync_pace  <= 1'b1;
            sync_due_reg <= 1'b0;
         end else if (dual_m && !a_seen_reg && !av_run_reg && tick_reg
                      && (vv_reg + paced_av_ms) >= esc_lim_reg && !sync_due_reg) begin
            a_stim <= 1'b1;
         end
         // Early A sense, or any A sense in non-tracking, wants a sync pace in dual modes
         if ((a_early && dual_m) || (a_ev && nontracking && dual_m)) begin
            sync_due_reg <= 1'b1;
         end else if (v_ev || v_stim) begin
            sync_due_reg <= 1'b0;
         end
      end
   end

   // Retrograde test and termination state machine
   typedef enum logic [1:0] {RCM_IDLE, RCM_BASE, RCM_TEST, RCM_SWITCHED} rcm_state_t;
   rcm_state_t  st_reg;
   logic [11:0] va_base_reg;
   logic [1:0]  pass_reg;
   logic [5:0]  period_reg;
   logic [1:0]  vs_run_reg;
   logic [1:0]  noa_run_reg;
   logic        va_meas;
   logic [11:0] va_diff;
   assign va_meas = a_ev && !a_early && vv_reg >= rcm_pkg::VA_FARFIELD_MS;
   assign va_diff = (vv_reg > va_base_reg) ? (vv_reg - va_base_reg) : (va_base_reg - vv_reg);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg            <= RCM_IDLE;
         va_base_reg       <= rcm_pkg::MS_RESET;
         pass_reg          <= 2'h0;
         period_reg        <= 6'h00;
         vs_run_reg        <= 2'h0;
         noa_run_reg       <= 2'h0;
         retro_test_active <= 1'b0;
         retro_confirmed   <= 1'b0;
         nontracking       <= 1'b0;
      end else begin
         if (v_ev) vs_run_reg <= (vs_run_reg == 2'h3) ? 2'h3 : vs_run_reg + 2'h1;
         else if (v_stim) vs_run_reg <= 2'h0;
         if (v_ev || v_stim) noa_run_reg <= a_seen_reg ? 2'h0 :
            ((noa_run_reg == 2'h3) ? 2'h3 : noa_run_reg + 2'h1);
         case (st_reg)
            RCM_IDLE: begin
               // Count paced cycles of atrial tracking
               if (v_stim && av_run_reg) period_reg <= period_reg + 6'h01;
               if (va_meas && period_reg >= rcm_pkg::TEST_PERIOD_CYC && track_m
                   && vv_reg < rcm_pkg::VA_RETRO_MAX_MS) begin
                  va_base_reg <= vv_reg;
                  pass_reg    <= 2'h0;
                  st_reg      <= RCM_BASE;
               end
               if (a_early && auto_switch_en && track_m) begin
                  nontracking <= 1'b1;
                  st_reg      <= RCM_SWITCHED;
               end
            end
            RCM_BASE: begin
               // Next cycle gets a lengthened AV delay
               if (v_stim) begin
                  retro_test_active <= 1'b1;
                  st_reg            <= RCM_TEST;
               end
            end
            RCM_TEST: begin
               if (va_meas) begin
                  retro_test_active <= 1'b0;
                  period_reg        <= 6'h00;
                  if (va_diff <= rcm_pkg::VA_TOL_MS) begin
                     if (pass_reg == rcm_pkg::TEST_REPEATS - 2'h1) begin
                        retro_confirmed <= 1'b1;
                        nontracking     <= 1'b1;
                        st_reg          <= RCM_SWITCHED;
                     end else begin
                        pass_reg <= pass_reg + 2'h1;
                        st_reg   <= RCM_BASE;
                     end
                  end else begin
                     st_reg <= RCM_IDLE;
                  end
               end
            end
            RCM_SWITCHED: begin
               // Monitoring continues; any end condition restores tracking
               if ((va_meas && vv_reg > rcm_pkg::VA_RETRO_MAX_MS) || a_sync_pace
                   || ((v_ev || v_stim) && a_cnt_reg >= 2'h2)
                   || vs_run_reg == rcm_pkg::VS_END_COUNT
                   || (vdd_m && noa_run_reg == rcm_pkg::NO_AS_END_COUNT)) begin
                  nontracking     <= 1'b0;
                  retro_confirmed <= 1'b0;
                  period_reg      <= 6'h00;
                  st_reg          <= RCM_IDLE;
               end
            end
            default: st_reg <= RCM_IDLE;
         endcase
      end
   end

   // Checks
   AST_PVE_CLASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (v_ev && !a_seen_reg) |=> premature_ventricular_event) else $error("pve missed");
   AST_EXT_FIRST: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (v_ev && pve_series_reg) |=> !ext_active) else $error("ext on later pve");
   AST_EXT_MODE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ((v_ev || v_stim) && !(post_ext_en && track_m)) |=> !ext_active)
      else $error("ext while off");
   AST_SYNC_FIRST: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pve_now && !sync_stim_en) |=> !a_stim || $past(tick_reg)) else $error("stim off");
   AST_TEST_VA: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (st_reg == RCM_BASE && $past(st_reg) == RCM_IDLE) |->
      va_base_reg < rcm_pkg::VA_RETRO_MAX_MS) else $error("test va");
   AST_CONF_NT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(retro_confirmed) |-> nontracking && pass_reg == 2'h2) else $error("confirm");
   AST_END_SYNC: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (st_reg == RCM_SWITCHED && a_sync_pace) |=> !nontracking) else $error("end sync");
   AST_END_VS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (st_reg == RCM_SWITCHED && vs_run_reg == 2'h3) |=> st_reg == RCM_IDLE)
      else $error("end vs");
   AST_TICK: assert property (@(posedge clk_sys) disable iff (!arst_n)
      tick_reg |=> !tick_reg [*2]) else $error("tick");
   COV_PVE: cover property (@(posedge clk_sys) disable iff (!arst_n) premature_ventricular_event);
   COV_TEST: cover property (@(posedge clk_sys) disable iff (!arst_n) retro_test_active);
   COV_CONF: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(retro_confirmed));
endmodule

// ### tb/rcm_heart.sv
// Heart model: drives the sense pins and counts stimuli it receives
module rcm_heart (
   input  wire logic clk_sys,
   output logic      a_sense_pin,
   output logic      v_sense_pin,
   input  wire logic a_stim,
   input  wire logic v_stim
);
   timeunit 1ns;
   timeprecision 100ps;

   int a_stim_seen;  // Atrial stimuli delivered to the model
   int v_stim_seen;  // Ventricular stimuli delivered to the model

   // Pins idle low between depolarisations
   initial begin
      a_sense_pin = 1'b0;
      v_sense_pin = 1'b0;
      a_stim_seen = 0;
      v_stim_seen = 0;
   end

   // Stimuli are single-cycle pulses, so count each high sample
   always @(posedge clk_sys) begin
      if (a_stim === 1'b1) begin
         a_stim_seen++;
      end
      if (v_stim === 1'b1) begin
         v_stim_seen++;
      end
   end

   // One depolarisation: four clocks high, then six low
   // Longer than two clocks so the synchroniser cannot miss it
   task automatic beat(input bit atrial);
      @(posedge clk_sys);
      #2;
      if (atrial) begin
         a_sense_pin = 1'b1;
      end else begin
         v_sense_pin = 1'b1;
      end
      repeat (4) @(posedge clk_sys);
      #2;
      a_sense_pin = 1'b0;
      v_sense_pin = 1'b0;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule

// ### tb/tb.sv
// Testbench: premature event handling and mode switching at the ports
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys;           // 40 MHz system clock
   logic        arst_n;            // Asynchronous reset, active low
   logic        a_sense_pin;       // From heart model
   logic        v_sense_pin;       // From heart model
   logic [1:0]  mode;              // Pacing mode code
   logic        post_ext_en;       // Escape extension enable
   logic        sync_stim_en;      // Synchronous atrial stimulation enable
   logic        auto_switch_en;    // Automatic mode switching
   logic [11:0] escape_ms;         // Escape interval
   logic [11:0] paced_av_ms;       // Paced AV delay
   logic [11:0] sensed_av_ms;      // Sensed AV delay
   logic [11:0] av_offset_ms;      // Sensed/paced offset
   logic [11:0] tracking_win_ms;   // Tracking window start
   logic [11:0] sync_interval_ms;  // Sync pace interval
   logic        a_stim;
   logic        v_stim;
   logic        a_sync_pace;
   logic        premature_ventricular_event;
   logic        ext_active;
   logic        retro_test_active;
   logic        retro_confirmed;
   logic        nontracking;
   int          fails;             // Mismatches seen
   int          compares;          // Comparisons made
   int          pve_cnt;           // Premature event pulses
   int          sync_cnt;          // Sync pace pulses
   int          base;              // Count before a scenario

   rcm_core i_dut (
      .clk_sys                     (clk_sys),
      .arst_n                      (arst_n),
      .a_sense_pin                 (a_sense_pin),
      .v_sense_pin                 (v_sense_pin),
      .mode                        (mode),
      .post_ext_en                 (post_ext_en),
      .sync_stim_en                (sync_stim_en),
      .auto_switch_en              (auto_switch_en),
      .escape_ms                   (escape_ms),
      .paced_av_ms                 (paced_av_ms),
      .sensed_av_ms                (sensed_av_ms),
      .av_offset_ms                (av_offset_ms),
      .tracking_win_ms             (tracking_win_ms),
      .sync_interval_ms            (sync_interval_ms),
      .a_stim                      (a_stim),
      .v_stim                      (v_stim),
      .a_sync_pace                 (a_sync_pace),
      .premature_ventricular_event (premature_ventricular_event),
      .ext_active                  (ext_active),
      .retro_test_active           (retro_test_active),
      .retro_confirmed             (retro_confirmed),
      .nontracking                 (nontracking)
   );

   rcm_heart i_heart (
      .clk_sys     (clk_sys),
      .a_sense_pin (a_sense_pin),
      .v_sense_pin (v_sense_pin),
      .a_stim      (a_stim),
      .v_stim      (v_stim)
   );

   // Clock, 25 ns period
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Pulse counters, sampled where outputs are settled
   always @(posedge clk_sys) begin
      if (premature_ventricular_event === 1'b1) begin
         pve_cnt++;
      end
      if (a_sync_pace === 1'b1) begin
         sync_cnt++;
      end
   end

   // Single-bit comparison
   task automatic check_bit(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Event count comparison
   task automatic check_cnt(input string name, input int exp, input int got);
      compares++;
      if (got != exp) begin
         fails++;
         $display("Error %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // Reset held for 16 cycles; also used mid-run to clear extensions
   task automatic do_reset();
      @(posedge clk_sys);
      #2;
      arst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      #2;
      arst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #2;
   endtask

   // Verdict, reached from the main sequence or the watchdog
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs about 40500 cycles, one ms tick included
   initial begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      final_report();
   end

   // Main sequence
   initial begin
      arst_n           = 1'b0;
      mode             = rcm_pkg::RCM_MODE_DUAL_TRACK;
      post_ext_en      = 1'b1;
      sync_stim_en     = 1'b1;
      auto_switch_en   = 1'b0;
      escape_ms        = 12'h3e8;
      paced_av_ms      = 12'h096;
      sensed_av_ms     = 12'h078;
      av_offset_ms     = 12'h01e;
      tracking_win_ms  = 12'h12c;
      sync_interval_ms = 12'h0fa;
      fails            = 0;
      compares         = 0;
      pve_cnt          = 0;
      sync_cnt         = 0;
      do_reset();
      // Quiet outputs after reset
      check_bit("ext_active", 1'b0, ext_active);
      check_bit("nontracking", 1'b0, nontracking);
      check_bit("retro_test_active", 1'b0, retro_test_active);
      check_bit("retro_confirmed", 1'b0, retro_confirmed);
      // Lone V sense: premature, extended; atrial interval too short for sync stim
      base = pve_cnt;
      i_heart.beat(1'b0);
      check_cnt("pve pulses", 1, pve_cnt - base);
      check_bit("ext_active", 1'b1, ext_active);
      check_cnt("a_stim", 0, i_heart.a_stim_seen);
      check_cnt("a_sync_pace", 0, sync_cnt);
      // A then V in the same cycle: not premature, no extension
      do_reset();
      base = pve_cnt;
      i_heart.beat(1'b1);
      i_heart.beat(1'b0);
      check_cnt("pve pulses", 0, pve_cnt - base);
      check_bit("ext_active", 1'b0, ext_active);
      // Extension only in the three listed modes
      for (int m = 0; m < 4; m++) begin
         do_reset();
         mode = 2'(m);
         i_heart.beat(1'b0);
         check_bit("ext_active", m != 3, ext_active);
      end
      // Extension switched off
      do_reset();
      mode        = rcm_pkg::RCM_MODE_DUAL_TRACK;
      post_ext_en = 1'b0;
      i_heart.beat(1'b0);
      check_bit("ext_active", 1'b0, ext_active);
      // Automatic switching: A sense well before the tracking window
      do_reset();
      auto_switch_en = 1'b1;
      i_heart.beat(1'b0);
      i_heart.beat(1'b1);
      repeat (10) @(posedge clk_sys);
      check_bit("nontracking", 1'b1, nontracking);
      check_bit("retro_confirmed", 1'b0, retro_confirmed);
      // Sensed V events end the switch only on the third in a row
      i_heart.beat(1'b0);
      check_bit("nontracking", 1'b1, nontracking);
      i_heart.beat(1'b0);
      check_bit("nontracking", 1'b0, nontracking);
      // Zero-length window: every A sense is in window, tracked, no switch
      do_reset();
      tracking_win_ms  = 12'h000;
      sync_interval_ms = 12'h000;
      sync_stim_en     = 1'b0;
      i_heart.beat(1'b0);
      check_cnt("a_stim", 0, i_heart.a_stim_seen);
      i_heart.beat(1'b1);
      check_bit("nontracking", 1'b0, nontracking);
      // One ms tick passes: AV delay and escape are still running
      repeat (40100) @(posedge clk_sys);
      #2;
      check_cnt("v_stim", 0, i_heart.v_stim_seen);
      check_cnt("a_stim", 0, i_heart.a_stim_seen);
      // Atrial interval now above the zero sync interval: first premature V stimulates
      sync_stim_en = 1'b1;
      i_heart.beat(1'b0);
      i_heart.beat(1'b0);
      check_cnt("a_stim", 1, i_heart.a_stim_seen);
      check_cnt("a_sync_pace", 0, sync_cnt);
      final_report();
   end
endmodule
